// ---- design/nvsp_ctrl.v ----
// program flash self-programming controller: reads, unlock, latch load, row erase/write
`timescale 1ns/1ps
`default_nettype none
`include "nvsp_regs.vh"
module nvsp_ctrl
(
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  input  wire        CONFIG_SPACE_SELECT,
  input  wire        PROGRAM_UNLOCK_ENABLE,
  input  wire        ERASE_SELECT,
  input  wire        LATCH_LOAD_ONLY,
  input  wire        READ_STROBE_SET,
  input  wire        GO_SET,
  input  wire        UNLOCK_KEY_WR,
  input  wire [7:0]  UNLOCK_KEY_DATA,
  input  wire [14:0] NVM_ADDRESS_PAIR,
  input  wire        DATA_PAIR_WR,
  input  wire [13:0] DATA_PAIR_WDATA,
  input  wire        PTR_READ,
  input  wire [14:0] PTR_ADDR,
  input  wire        PTR_HIGH_BYTE,
  input  wire        PTR_WRITE,
  input  wire [1:0]  SELF_WRITE_PROTECT_FIELD,
  input  wire        CODE_PROTECT_N,
  input  wire        EXT_READ,
  input  wire        EXT_WRITE,
  input  wire        EXT_BULK_ERASE,
  input  wire        NVM_DONE_FLAG_CLR,
  input  wire        NVM_DONE_IRQ_ENABLE,
  output reg  [13:0] NVM_DATA_PAIR,
  output reg  [7:0]  PTR_DATA,
  output reg         READ_STROBE,
  output reg         GO_BIT,
  output reg         CPU_STALL,
  output reg         NVM_DONE_FLAG,
  output reg         NVM_DONE_IRQ,
  output reg         EXT_ACCESS_DENIED,
  output reg         CODE_PROTECT_ACTIVE,
  output reg         WRITE_ERROR
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_READ  = 2'd1;
  localparam ST_BUSY  = 2'd2;
  // program time counts system clocks; the timer width covers the count
  localparam integer PROG_INT = `NVSP_PROG_CYCLES;
  localparam [11:0]  PROG_CNT = PROG_INT[11:0];

  reg [13:0] pfm_mem [0:`NVSP_ARRAY_WORDS-1];
  reg [13:0] uid_mem [0:`NVSP_ID_WORDS-1];
  reg [13:0] latch_mem [0:`NVSP_ROW_WORDS-1];
  reg [`NVSP_ROW_WORDS-1:0] latch_vld_ff;
  reg [1:0]  state_ff;
  reg [11:0] tmr_ff;
  reg [1:0]  key_ff;
  reg        cp_sticky_ff;
  reg        op_erase_ff;
  reg        op_cfg_ff;
  reg [14:0] op_addr_ff;
  integer    i;
  parameter [13:0] REV_ID_VAL = 14'h2001; // arbitrary value
  parameter [13:0] DEV_ID_VAL = 14'h3001; // arbitrary value

  // true when a self-write at this array address is barred
  function is_protected;
    input [1:0]  wrt;
    input        cfg;
    input [14:0] a;
    begin
      if (cfg)
        is_protected = (a[3:0] >= 4'h4);
      else
        case (wrt)
          `NVSP_WP_NONE: is_protected = 1'b0;
          `NVSP_WP_Q1:   is_protected = (a[12:0] <= `NVSP_WP_Q1_END);
          `NVSP_WP_HALF: is_protected = (a[12:0] <= `NVSP_WP_HALF_END);
          default:       is_protected = 1'b1;
        endcase
    end
  endfunction

  function [13:0] fetch;
    input        cfg;
    input [14:0] a;
    begin
      if (!cfg)
        fetch = pfm_mem[a[12:0]];
      else if (a[3:0] < `NVSP_ID_WORDS)
        fetch = uid_mem[a[1:0]];
      else if (a[3:0] == `NVSP_ID_REV_IDX)
        fetch = REV_ID_VAL;
      else if (a[3:0] == `NVSP_ID_DEV_IDX)
        fetch = DEV_ID_VAL;
      else
        fetch = 14'h0000;
    end
  endfunction

  // go is honoured only one cycle after the second key write
  wire go_ok = GO_SET & (key_ff == 2'd2) & PROGRAM_UNLOCK_ENABLE;
  wire prot  = is_protected(SELF_WRITE_PROTECT_FIELD, CONFIG_SPACE_SELECT, NVM_ADDRESS_PAIR);
  wire [4:0] lat_idx = NVM_ADDRESS_PAIR[`NVSP_ROW_BITS-1:0];
  // a read strobe outranks a go in the same cycle, in both processes below
  wire idle_go   = (state_ff == ST_IDLE) & ~READ_STROBE_SET & go_ok;
  wire do_load   = idle_go & ~prot & LATCH_LOAD_ONLY & ~ERASE_SELECT;
  wire prog_done = (state_ff == ST_BUSY) & (tmr_ff == 12'h001);

  // a first key write restarts the sequence; any other write, or a cycle without one, breaks it
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      key_ff <= 2'd0;
    else if (UNLOCK_KEY_WR && UNLOCK_KEY_DATA == `NVSP_KEY_FIRST)
      key_ff <= 2'd1;
    else if (UNLOCK_KEY_WR && UNLOCK_KEY_DATA == `NVSP_KEY_SECOND && key_ff == 2'd1)
      key_ff <= 2'd2;
    else
      key_ff <= 2'd0;
  end

  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_ff            <= ST_IDLE;
      tmr_ff              <= 12'h000;
      READ_STROBE         <= 1'b0;
      GO_BIT              <= 1'b0;
      CPU_STALL           <= 1'b0;
      NVM_DATA_PAIR       <= 14'h0000;
      PTR_DATA            <= 8'h00;
      NVM_DONE_FLAG       <= 1'b0;
      WRITE_ERROR         <= 1'b0;
      latch_vld_ff        <= {`NVSP_ROW_WORDS{1'b0}};
      op_erase_ff         <= 1'b0;
      op_cfg_ff           <= 1'b0;
      op_addr_ff          <= 15'h0000;
    end
    else
    begin
      // a clear loses to a completion in the same cycle, whose set comes later
      if (NVM_DONE_FLAG_CLR)
        NVM_DONE_FLAG <= 1'b0;
      if (PTR_READ && state_ff == ST_IDLE)
      begin
        // pointer path is read-only; PTR_WRITE is simply never acted on
        PTR_DATA <= PTR_HIGH_BYTE ? {2'b00, pfm_mem[PTR_ADDR[12:0]][13:8]}
                                  : pfm_mem[PTR_ADDR[12:0]][7:0];
      end
      if (DATA_PAIR_WR)
        NVM_DATA_PAIR <= DATA_PAIR_WDATA;
      case (state_ff)
        ST_IDLE:
        begin
          CPU_STALL <= PTR_READ;
          if (READ_STROBE_SET)
          begin
            READ_STROBE   <= 1'b1;
            CPU_STALL     <= 1'b1;
            NVM_DATA_PAIR <= fetch(CONFIG_SPACE_SELECT, NVM_ADDRESS_PAIR);
            state_ff      <= ST_READ;
          end
          else if (go_ok && prot)
          begin
            GO_BIT      <= 1'b0;
            WRITE_ERROR <= 1'b1;
          end
          else if (do_load)
          begin
            latch_vld_ff[lat_idx] <= 1'b1;
          end
          else if (go_ok)
          begin
            GO_BIT      <= 1'b1;
            CPU_STALL   <= 1'b1;
            WRITE_ERROR <= 1'b0;
            op_erase_ff <= ERASE_SELECT;
            op_cfg_ff   <= CONFIG_SPACE_SELECT;
            op_addr_ff  <= NVM_ADDRESS_PAIR;
            tmr_ff      <= PROG_CNT;
            state_ff    <= ST_BUSY;
          end
        end
        ST_READ:
        begin
          READ_STROBE <= 1'b0;
          CPU_STALL   <= 1'b0;
          state_ff    <= ST_IDLE;
        end
        ST_BUSY:
        begin
          if (prog_done)
          begin
            GO_BIT        <= 1'b0;
            CPU_STALL     <= 1'b0;
            NVM_DONE_FLAG <= 1'b1;
            if (!op_erase_ff)
              latch_vld_ff <= {`NVSP_ROW_WORDS{1'b0}};
            state_ff <= ST_IDLE;
          end
          tmr_ff <= tmr_ff - 12'h001;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // array contents: no reset, flash is nonvolatile
  always @(posedge CLK_SYS)
  begin
    if (do_load)
      latch_mem[lat_idx] <= NVM_DATA_PAIR;
    if (EXT_BULK_ERASE)
    begin
      for (i = 0; i < `NVSP_ARRAY_WORDS; i = i + 1)
        pfm_mem[i] <= `NVSP_ERASED_WORD;
      for (i = 0; i < `NVSP_ID_WORDS; i = i + 1)
        uid_mem[i] <= `NVSP_ERASED_WORD;
    end
    else if (prog_done)
    begin
      for (i = 0; i < `NVSP_ROW_WORDS; i = i + 1)
      begin
        if (op_cfg_ff)
        begin
          if (i < `NVSP_ID_WORDS)
            uid_mem[i] <= op_erase_ff ? `NVSP_ERASED_WORD
                        : (latch_vld_ff[i] ? uid_mem[i] & latch_mem[i] : uid_mem[i]);
        end
        else if (op_erase_ff)
          pfm_mem[{op_addr_ff[12:5], i[4:0]}] <= `NVSP_ERASED_WORD;
        else if (latch_vld_ff[i])
          pfm_mem[{op_addr_ff[12:5], i[4:0]}] <=
            pfm_mem[{op_addr_ff[12:5], i[4:0]}] & latch_mem[i];
      end
    end
  end

  // protection is latched and only an external bulk erase or a system reset drops it
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      cp_sticky_ff <= 1'b0;
    else if (EXT_BULK_ERASE)
      cp_sticky_ff <= 1'b0;
    else if (!CODE_PROTECT_N)
      cp_sticky_ff <= 1'b1;
  end

  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      CODE_PROTECT_ACTIVE <= 1'b0;
    else
      CODE_PROTECT_ACTIVE <= cp_sticky_ff | ~CODE_PROTECT_N;
  end

  // gate follows the registered protection, so it lags a pin change by two clocks
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      EXT_ACCESS_DENIED <= 1'b0;
    else
      EXT_ACCESS_DENIED <= CODE_PROTECT_ACTIVE & (EXT_READ | EXT_WRITE);
  end

  // interrupt request is the flag masked by its enable, one clock behind
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      NVM_DONE_IRQ <= 1'b0;
    else
      NVM_DONE_IRQ <= NVM_DONE_FLAG & NVM_DONE_IRQ_ENABLE;
  end
endmodule // nvsp_ctrl
`default_nettype wire

// ---- design/nvsp_regs.vh ----
// constants for the program flash self-programming controller
`ifndef NVSP_REGS_VH
`define NVSP_REGS_VH
`define NVSP_WORD_W        14
`define NVSP_ADDR_W        15
`define NVSP_ROW_WORDS     32
`define NVSP_ROW_BITS      5
`define NVSP_ARRAY_WORDS   8192
`define NVSP_ERASED_WORD   14'h3FFF
`define NVSP_KEY_FIRST     8'h55
`define NVSP_KEY_SECOND    8'hAA
`define NVSP_WP_NONE       2'b11
`define NVSP_WP_Q1         2'b10
`define NVSP_WP_HALF       2'b01
`define NVSP_WP_ALL        2'b00
`define NVSP_WP_Q1_END     13'h07FF
`define NVSP_WP_HALF_END   13'h0FFF
`define NVSP_ID_REV_IDX    4'h5
`define NVSP_ID_DEV_IDX    4'h6
`define NVSP_ID_WORDS      4
`define NVSP_T_PROG_US     2
`define NVSP_CLK_MHZ       125
`define NVSP_PROG_CYCLES   (`NVSP_T_PROG_US * `NVSP_CLK_MHZ)
`endif

// ---- verification/nvsp_assertions.sv ----
// checker for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
`include "nvsp_regs.vh"
module nvsp_chk
(
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  input wire logic       READ_STROBE_SET,
  input wire logic       GO_SET,
  input wire logic       UNLOCK_KEY_WR,
  input wire logic [7:0] UNLOCK_KEY_DATA,
  input wire logic       PTR_READ,
  input wire logic       NVM_DONE_IRQ_ENABLE,
  input wire logic       READ_STROBE,
  input wire logic       GO_BIT,
  input wire logic       CPU_STALL,
  input wire logic       NVM_DONE_FLAG,
  input wire logic       NVM_DONE_IRQ,
  input wire logic       WRITE_ERROR
);
  logic       key1_ff;
  logic       key2_ff;
  logic [8:0] cnt_ff;
  // key history rebuilt here so a go can be judged against it
  always @(posedge CLK_SYS)
  begin
    key1_ff <= !SYS_RST && UNLOCK_KEY_WR && UNLOCK_KEY_DATA == 8'h55;
    key2_ff <= !SYS_RST && key1_ff && UNLOCK_KEY_WR && UNLOCK_KEY_DATA == 8'hAA;
    cnt_ff  <= (GO_BIT && !SYS_RST) ? cnt_ff + 9'h001 : 9'h000;
  end
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  rd_start_a: assert property (READ_STROBE_SET && !CPU_STALL |=> READ_STROBE && CPU_STALL)
    else $error("read not started");
  rd_clear_a: assert property (READ_STROBE |=> !READ_STROBE && !CPU_STALL)
    else $error("read strobe stuck");
  ptr_stall_a: assert property (PTR_READ && !CPU_STALL |=> CPU_STALL ##1 !CPU_STALL)
    else $error("pointer read stall wrong");
  go_stall_a: assert property (GO_BIT |-> CPU_STALL) else $error("go without stall");
  go_time_a: assert property ($fell(GO_BIT) |-> cnt_ff == `NVSP_PROG_CYCLES)
    else $error("program time wrong");
  done_flag_a: assert property ($fell(GO_BIT) |-> NVM_DONE_FLAG) else $error("no done flag");
  done_irq_a: assert property (NVM_DONE_IRQ == $past(NVM_DONE_FLAG && NVM_DONE_IRQ_ENABLE))
    else $error("irq mismatch");
  bad_key_a: assert property (GO_SET && !key2_ff && !GO_BIT |=> !GO_BIT)
    else $error("go taken without keys");
  wp_block_a: assert property (WRITE_ERROR |-> !GO_BIT) else $error("protected op ran");
  cover property ($fell(GO_BIT));
  cover property (WRITE_ERROR);
  cover property (READ_STROBE);
endmodule // nvsp_chk
bind nvsp_ctrl nvsp_chk u_chk (.CLK_SYS, .SYS_RST, .READ_STROBE_SET, .GO_SET, .UNLOCK_KEY_WR,
  .UNLOCK_KEY_DATA, .PTR_READ, .NVM_DONE_IRQ_ENABLE, .READ_STROBE, .GO_BIT, .CPU_STALL,
  .NVM_DONE_FLAG, .NVM_DONE_IRQ, .WRITE_ERROR);
`default_nettype wire

// ---- verification/nvsp_cpu.sv ----
// cpu core model issuing reads, key writes, data writes and go
`timescale 1ns/1ps
`default_nettype none
module nvsp_cpu
(
  input  wire logic        clk,
  input  wire logic        stall,
  output var  logic        rd_set,
  output var  logic        go_set,
  output var  logic        key_wr,
  output var  logic [7:0]  key,
  output var  logic        dat_wr,
  output var  logic [13:0] dat,
  output var  logic        ptr_rd
);
  initial {rd_set, go_set, key_wr, key, dat_wr, dat, ptr_rd} = '0;
  task strobe(input logic ptr);
    @(negedge clk);
    ptr_rd = ptr;
    rd_set = !ptr;
    @(negedge clk);
    ptr_rd = 0;
    rd_set = 0;
  endtask
  task load(input logic [13:0] d);
    @(negedge clk);
    dat_wr = 1;
    dat = d;
    @(negedge clk);
    dat_wr = 0;
    dat = ~d;
  endtask
  // no interrupt is taken here, so the three writes stay back to back
  task unlock(input logic [7:0] k1, input logic [7:0] k2);
    integer i;
    @(negedge clk);
    key_wr = 1;
    key = k1;
    @(negedge clk);
    key = k2;
    @(negedge clk);
    key_wr = 0;
    key = ~k2;
    go_set = 1;
    @(negedge clk);
    go_set = 0;
    for (i = 0; i < 300 && stall; i++) @(negedge clk);
  endtask
endmodule // nvsp_cpu
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
`include "nvsp_regs.vh"
module testbench;
  logic clk = 0, rst = 1, cfg = 0, wen = 0, ers = 0, llo = 0, hi = 0, bulk = 0, fclr = 0;
  logic [14:0] adr = 15'h0123;
  logic [1:0] wp = 2'h3;
  logic pw = 0, cpn = 1, erd = 0, ewr = 0, ien = 1;
  wire rs, gs, kw, dw, pr, rsb, gob, stl, flg, irq, wer, den, cpa;
  wire [7:0] kd, pd;
  wire [13:0] dd, dp;
  integer mismatches = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  nvsp_cpu cpu (.clk(clk), .stall(stl), .rd_set(rs), .go_set(gs), .key_wr(kw), .key(kd),
    .dat_wr(dw), .dat(dd), .ptr_rd(pr));
  nvsp_ctrl #(.REV_ID_VAL(14'h1234), .DEV_ID_VAL(14'h0ABC)) uut ( // arbitrary values
    .CLK_SYS(clk), .SYS_RST(rst),
    .CONFIG_SPACE_SELECT(cfg), .PROGRAM_UNLOCK_ENABLE(wen), .ERASE_SELECT(ers),
    .LATCH_LOAD_ONLY(llo), .READ_STROBE_SET(rs), .GO_SET(gs), .UNLOCK_KEY_WR(kw),
    .UNLOCK_KEY_DATA(kd), .NVM_ADDRESS_PAIR(adr), .DATA_PAIR_WR(dw), .DATA_PAIR_WDATA(dd),
    .PTR_READ(pr), .PTR_ADDR(adr), .PTR_HIGH_BYTE(hi), .PTR_WRITE(pw),
    .SELF_WRITE_PROTECT_FIELD(wp), .CODE_PROTECT_N(cpn), .EXT_READ(erd), .EXT_WRITE(ewr),
    .EXT_BULK_ERASE(bulk), .NVM_DONE_FLAG_CLR(fclr), .NVM_DONE_IRQ_ENABLE(ien),
    .NVM_DATA_PAIR(dp), .PTR_DATA(pd), .READ_STROBE(rsb), .GO_BIT(gob), .CPU_STALL(stl),
    .NVM_DONE_FLAG(flg), .NVM_DONE_IRQ(irq), .EXT_ACCESS_DENIED(den),
    .CODE_PROTECT_ACTIVE(cpa), .WRITE_ERROR(wer));
  task chk(input logic [13:0] g, input logic [13:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d of %0d checks", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 0;
    cpn = 0;
    erd = 1;
    repeat (2) @(negedge clk);
    cpn = 1;
    @(negedge clk);
    chk(cpa, 14'h0001);
    chk(den, 14'h0001);
    erd = 0;
    ewr = 1;
    bulk = 1;
    @(negedge clk);
    bulk = 0;
    chk(den, 14'h0001);
    repeat (2) @(negedge clk);
    chk(cpa, 14'h0000);
    chk(den, 14'h0000);
    ewr = 0;
    cpu.strobe(0);
    chk(dp, `NVSP_ERASED_WORD);
    chk(rsb, 14'h0001);
    chk(stl, 14'h0001);
    @(negedge clk);
    chk(rsb, 14'h0000);
    wen = 1;
    llo = 1;
    cpu.load(14'h1A5C);
    chk(dp, 14'h1A5C);
    cpu.unlock(8'h55, 8'hAA);
    llo = 0;
    cpu.unlock(8'h55, 8'hAA);
    chk(gob, 14'h0000);
    chk(flg, 14'h0001);
    @(negedge clk);
    chk(irq, 14'h0001);
    ien = 0;
    @(negedge clk);
    chk(irq, 14'h0000);
    ien = 1;
    cpu.strobe(0);
    chk(dp, 14'h1A5C);
    hi = 1;
    pw = 1;
    cpu.strobe(1);
    pw = 0;
    chk(pd, 14'h001A);
    cpu.strobe(0);
    chk(dp, 14'h1A5C);
    fclr = 1;
    @(negedge clk);
    fclr = 0;
    ers = 1;
    cpu.unlock(8'h55, 8'h55);
    chk(flg, 14'h0000);
    wen = 0;
    cpu.unlock(8'h55, 8'hAA);
    chk(flg, 14'h0000);
    wen = 1;
    wp = 2'h0;
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0001);
    chk(gob, 14'h0000);
    cpu.strobe(0);
    chk(dp, 14'h1A5C);
    wp = 2'h3;
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0000);
    cpu.strobe(0);
    chk(dp, `NVSP_ERASED_WORD);
    wp = 2'h2;
    adr = 15'h0900;
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0000);
    ers = 0;
    cfg = 1;
    adr = 15'h0005;
    cpu.strobe(0);
    chk(dp, 14'h1234);
    adr = 15'h0006;
    cpu.strobe(0);
    chk(dp, 14'h0ABC);
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0001);
    adr = 15'h0000;
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0000);
    cfg = 0;
    adr = 15'h0900;
    wp = 2'h1;
    cpu.unlock(8'h55, 8'hAA);
    chk(wer, 14'h0001);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
